// ---- shared/csr_defines.vh ----
`ifndef CSR_DEFINES_VH
`define CSR_DEFINES_VH
// Register indices (byte address = 4 * index)
`define CSR_IDX_INDIRECT_DATA 9'h180
`define CSR_IDX_OPTION 9'h181
`define CSR_IDX_PC_LOW 9'h182
`define CSR_IDX_STATUS 9'h183
`define CSR_IDX_POINTER 9'h184
`define CSR_IDX_PORTB_DIR 9'h186
`define CSR_IDX_PC_LATCH 9'h18A
`define CSR_IDX_INT_CTRL 9'h18B
// Status bit positions
`define CSR_ST_CARRY 0
`define CSR_ST_DIGIT 1
`define CSR_ST_ZERO 2
`define CSR_ST_PD 3
`define CSR_ST_TO 4
`define CSR_ST_RP0 5
`define CSR_ST_RP1 6
`define CSR_ST_IRP 7
// Reset values
`define CSR_RST_OPTION 8'hFF
`define CSR_RST_PC_LOW 8'h00
`define CSR_RST_PORTB_DIR 8'hFF
`define CSR_RST_PC_LATCH 5'h00
`define CSR_RST_STATUS_POR 8'h18
`define CSR_RST_INT_CTRL 8'h00
`define CSR_RST_POINTER 8'h00
// ALU operation codes
`define CSR_OP_NONE 3'h0
`define CSR_OP_ADD 3'h1
`define CSR_OP_SUB 3'h2
`define CSR_OP_LOGIC 3'h3
`define CSR_OP_CLEAR 3'h4
`define CSR_OP_RRF 3'h5
`define CSR_OP_RLF 3'h6
`define CSR_OP_MOVE 3'h7
`endif

// ---- src/csr_core_status_bank.v ----
// How it works
// - The status register holds zero, digit carry and carry, the two reset-cause bits and three bank selects.
// - Any instruction may name the status register as its destination like any other file register.
// - When the instruction affects zero, digit carry or carry, the data write to those bits is dropped and the ALU flags land instead.
// - The timeout and powerdown cause bits ignore all writes and move only on reset, sleep and watchdog events.
// - A clear of the status register gives 000uu1uu: bank selects cleared, zero set, others kept.
// - In subtraction carry is an inverted borrow and digit carry an inverted low nibble borrow.
// - Unimplemented addresses and bits read as zero.
// - Master clear, brown-out and watchdog resets apply the non power-up values, keeping some bits.
// - For add and subtract carry is 1 exactly when bit 7 carries out.
// - Subtraction adds the two's complement of the second operand.
// - Rotates load carry with the bit shifted out, low bit right and high bit left.
`timescale 1ns/1ps
`include "csr_defines.vh"
module csr_core_status_bank (
    // Clock and reset
    input wire i_core_clk,
    input wire i_srst,
    // Device reset and power events
    input wire i_por,
    input wire i_other_rst,
    input wire i_wdt_reset,
    input wire i_clrwdt,
    input wire i_sleep,
    input wire i_wdt_wake,
    // Instruction datapath
    input wire i_ex_valid,
    input wire [2:0] i_ex_op,
    input wire [8:0] i_ex_dest,
    input wire [7:0] i_ex_a,
    input wire [7:0] i_ex_b,
    input wire i_ex_flag_update,
    output reg [7:0] o_ex_result,
    // Indirect memory port
    output wire [8:0] o_mem_addr,
    output wire o_mem_we,
    output wire [7:0] o_mem_wdata,
    input wire [7:0] i_mem_rdata,
    // Register state
    output wire [7:0] o_status,
    output wire [7:0] o_option,
    output wire [7:0] o_portb_dir,
    output wire [4:0] o_pc_latch,
    output wire [7:0] o_int_ctrl,
    output wire [7:0] o_pc_low,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr
);
    // Register state
    reg [7:0] status_q;
    reg [7:0] option_q;
    reg [7:0] pc_low_q;
    reg [7:0] pointer_q;
    reg [7:0] portb_dir_q;
    reg [4:0] pc_latch_q;
    reg [7:0] int_ctrl_q;
    // ALU working values
    reg [7:0] status_d;
    reg [8:0] sum;
    reg [4:0] nib;
    reg [7:0] res;
    reg res_c;
    reg res_dc;
    reg res_z;
    reg has_c;
    reg has_dc;
    // Decode nets
    wire apb_wr;
    wire [8:0] apb_idx;
    wire ex_st;
    wire ex_ind;
    wire ex_wr;
    wire [8:0] wr_idx;
    wire [7:0] wr_data;
    wire [7:0] b_eff;
    wire apb_ind;
    wire st_wr;
    wire to_set;
    wire to_clr;
    wire pd_set;
    wire pd_clr;
    wire wr_any;
    wire wr_option;
    wire wr_pc_low;
    wire wr_pointer;
    wire wr_portb_dir;
    wire wr_pc_latch;
    wire wr_int_ctrl;

    // Bus handshake, no wait states
    assign apb_wr = psel & penable & pwrite;
    assign apb_idx = paddr[10:2];
    assign pready = 1'b1;
    assign pslverr = 1'b0;

    // Subtrahend inverted; the carry-in of 1 in the sum completes the two's complement
    assign b_eff = (i_ex_op == `CSR_OP_SUB) ? ~i_ex_b : i_ex_b;

    // ALU result and flags
    always @* begin
        sum = 9'h000;
        nib = 5'h00;
        res = i_ex_a;
        res_c = status_q[`CSR_ST_CARRY];
        res_dc = status_q[`CSR_ST_DIGIT];
        has_c = 1'b0;
        has_dc = 1'b0;
        case (i_ex_op)
            `CSR_OP_ADD, `CSR_OP_SUB: begin
                sum = {1'b0, i_ex_a} + {1'b0, b_eff} + {8'h00, i_ex_op == `CSR_OP_SUB};
                nib = {1'b0, i_ex_a[3:0]} + {1'b0, b_eff[3:0]}
                    + {4'h0, i_ex_op == `CSR_OP_SUB};
                res = sum[7:0];
                res_c = sum[8];
                res_dc = nib[4];
                has_c = 1'b1;
                has_dc = 1'b1;
            end
            `CSR_OP_LOGIC: begin
                res = i_ex_b;
            end
            `CSR_OP_CLEAR: begin
                res = 8'h00;
            end
            `CSR_OP_RRF: begin
                res = {status_q[`CSR_ST_CARRY], i_ex_a[7:1]};
                res_c = i_ex_a[0];
                has_c = 1'b1;
            end
            `CSR_OP_RLF: begin
                res = {i_ex_a[6:0], status_q[`CSR_ST_CARRY]};
                res_c = i_ex_a[7];
                has_c = 1'b1;
            end
            `CSR_OP_MOVE: begin
                res = i_ex_b;
            end
            default: begin
                res = i_ex_a;
            end
        endcase
        res_z = (res == 8'h00);
    end

    // Datapath view of the ALU result
    always @* begin
        o_ex_result = res;
    end

    // Bus write to the indirect port, dropped when an instruction runs
    assign apb_ind = apb_wr & ~ex_st & (apb_idx == `CSR_IDX_INDIRECT_DATA);

    // Indirect port decode
    assign ex_st = i_ex_valid & (i_ex_op != `CSR_OP_NONE);
    assign ex_ind = ex_st & (i_ex_dest == `CSR_IDX_INDIRECT_DATA);
    assign o_mem_addr = {status_q[`CSR_ST_IRP], pointer_q};
    assign o_mem_we = ex_ind | apb_ind;
    assign o_mem_wdata = ex_ind ? res : pwdata[7:0];

    // Shared write path, instruction has priority
    assign ex_wr = ex_st;
    assign wr_idx = ex_wr ? i_ex_dest : apb_idx;
    assign wr_data = ex_wr ? res : pwdata[7:0];

    // Status destination decode
    assign st_wr = (ex_wr | apb_wr) && (wr_idx == `CSR_IDX_STATUS);

    // Cause bit events; sleep beats clear, watchdog clears timeout last
    assign to_set = i_clrwdt | i_sleep;
    assign to_clr = i_wdt_reset | i_wdt_wake;
    assign pd_set = i_clrwdt & ~i_sleep;
    assign pd_clr = i_sleep;

    // Status next value
    always @* begin
        status_d = status_q;
        if (st_wr) begin
            status_d[7:5] = wr_data[7:5];
            status_d[2:0] = wr_data[2:0];
        end
        if (ex_wr && i_ex_flag_update) begin
            status_d[`CSR_ST_ZERO] = res_z;
            if (has_dc)
                status_d[`CSR_ST_DIGIT] = res_dc;
            else if (wr_idx == `CSR_IDX_STATUS)
                status_d[`CSR_ST_DIGIT] = status_q[`CSR_ST_DIGIT];
            if (has_c)
                status_d[`CSR_ST_CARRY] = res_c;
            else if (wr_idx == `CSR_IDX_STATUS)
                status_d[`CSR_ST_CARRY] = status_q[`CSR_ST_CARRY];
        end
        // Cause bits only from device events
        if (to_set)
            status_d[`CSR_ST_TO] = 1'b1;
        if (pd_set)
            status_d[`CSR_ST_PD] = 1'b1;
        if (pd_clr)
            status_d[`CSR_ST_PD] = 1'b0;
        if (to_clr)
            status_d[`CSR_ST_TO] = 1'b0;
    end

    // Per-register write strobes, shared by both sources
    assign wr_any = ex_wr | apb_wr;
    assign wr_option = wr_any & (wr_idx == `CSR_IDX_OPTION);
    assign wr_pc_low = wr_any & (wr_idx == `CSR_IDX_PC_LOW);
    assign wr_pointer = wr_any & (wr_idx == `CSR_IDX_POINTER);
    assign wr_portb_dir = wr_any & (wr_idx == `CSR_IDX_PORTB_DIR);
    assign wr_pc_latch = wr_any & (wr_idx == `CSR_IDX_PC_LATCH);
    assign wr_int_ctrl = wr_any & (wr_idx == `CSR_IDX_INT_CTRL);

    // Status storage, power-up and other reset values
    always @(posedge i_core_clk) begin
        if (i_srst | i_por) begin
            status_q <= `CSR_RST_STATUS_POR;
        end else if (i_other_rst) begin
            // Bank selects cleared, timeout from cause, low bits from status next value
            status_q <= {3'b000, ~i_wdt_reset, status_d[3:0]};
        end else begin
            status_q <= status_d;
        end
    end

    // Prescaler option, reloaded by every reset
    always @(posedge i_core_clk) begin
        if (i_srst | i_por | i_other_rst) begin
            option_q <= `CSR_RST_OPTION;
        end else if (wr_option) begin
            option_q <= wr_data;
        end
    end

    // Program counter low byte
    always @(posedge i_core_clk) begin
        if (i_srst | i_por | i_other_rst) begin
            pc_low_q <= `CSR_RST_PC_LOW;
        end else if (wr_pc_low) begin
            pc_low_q <= wr_data;
        end
    end

    // Indirect pointer, kept over other resets
    always @(posedge i_core_clk) begin
        if (i_srst | i_por) begin
            pointer_q <= `CSR_RST_POINTER;
        end else if (wr_pointer & ~i_other_rst) begin
            pointer_q <= wr_data;
        end
    end

    // Port direction
    always @(posedge i_core_clk) begin
        if (i_srst | i_por | i_other_rst) begin
            portb_dir_q <= `CSR_RST_PORTB_DIR;
        end else if (wr_portb_dir) begin
            portb_dir_q <= wr_data;
        end
    end

    // Program counter upper latch, five bits only
    always @(posedge i_core_clk) begin
        if (i_srst | i_por | i_other_rst) begin
            pc_latch_q <= `CSR_RST_PC_LATCH;
        end else if (wr_pc_latch) begin
            pc_latch_q <= wr_data[4:0];
        end
    end

    // Interrupt control, low bit kept over other resets
    always @(posedge i_core_clk) begin
        if (i_srst | i_por) begin
            int_ctrl_q <= `CSR_RST_INT_CTRL;
        end else if (i_other_rst) begin
            int_ctrl_q <= {7'h00, int_ctrl_q[0]};
        end else if (wr_int_ctrl) begin
            int_ctrl_q <= wr_data;
        end
    end

    // APB read mux, unmapped reads zero
    always @* begin
        case (apb_idx)
            `CSR_IDX_INDIRECT_DATA: prdata = {24'h000000, i_mem_rdata};
            `CSR_IDX_OPTION: prdata = {24'h000000, option_q};
            `CSR_IDX_PC_LOW: prdata = {24'h000000, pc_low_q};
            `CSR_IDX_STATUS: prdata = {24'h000000, status_q};
            `CSR_IDX_POINTER: prdata = {24'h000000, pointer_q};
            `CSR_IDX_PORTB_DIR: prdata = {24'h000000, portb_dir_q};
            `CSR_IDX_PC_LATCH: prdata = {27'h0, pc_latch_q};
            `CSR_IDX_INT_CTRL: prdata = {24'h000000, int_ctrl_q};
            default: prdata = 32'h00000000;
        endcase
    end

    assign o_status = status_q;
    assign o_option = option_q;
    assign o_portb_dir = portb_dir_q;
    assign o_pc_latch = pc_latch_q;
    assign o_int_ctrl = int_ctrl_q;
    assign o_pc_low = pc_low_q;
endmodule

// ---- verification/csr_status_monitor.sv ----
`timescale 1ns/1ps
`include "csr_defines.vh"
module csr_status_monitor (
    // Clock, reset and events
    input wire logic i_core_clk, input wire logic i_srst, input wire logic i_por,
    input wire logic i_other_rst, input wire logic i_wdt_reset, input wire logic i_clrwdt,
    input wire logic i_sleep, input wire logic i_wdt_wake,
    // Instruction datapath
    input wire logic i_ex_valid, input wire logic [2:0] i_ex_op,
    input wire logic [8:0] i_ex_dest, input wire logic i_ex_flag_update,
    input wire logic [7:0] i_ex_a, input wire logic [7:0] i_ex_b,
    // Register state and bus
    input wire logic [7:0] o_status, input wire logic [7:0] o_option,
    input wire logic [7:0] o_portb_dir, input wire logic psel,
    input wire logic [11:0] paddr, input wire logic [31:0] prdata
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_srst);
    // No reset or power event this cycle
    wire quiet = !(i_por | i_other_rst | i_wdt_reset | i_clrwdt | i_sleep | i_wdt_wake);
    // Flag-setting instruction aimed at status
    wire st_fu = i_ex_valid && i_ex_flag_update && quiet && i_ex_dest == `CSR_IDX_STATUS;
    chk_cause_bits_kept: assert property (quiet |=> $stable(o_status[4:3]))
        else $error("cause bits moved without event");
    chk_clear_status: assert property (st_fu && i_ex_op == `CSR_OP_CLEAR |=>
        o_status[7:5] == 3'h0 && o_status[2] && $stable(o_status[1:0]))
        else $error("clear of status wrong");
    chk_add_carry: assert property (st_fu && i_ex_op == `CSR_OP_ADD |=>
        o_status[0] == $past(i_ex_a + i_ex_b > 9'h0FF)) else $error("add carry wrong");
    chk_sub_borrow: assert property (st_fu && i_ex_op == `CSR_OP_SUB |=>
        o_status[0] == $past(i_ex_a >= i_ex_b)
        && o_status[1] == $past(i_ex_a[3:0] >= i_ex_b[3:0])) else $error("sub borrow wrong");
    chk_rotate_carry: assert property (i_ex_valid && i_ex_flag_update && quiet
        && i_ex_op == `CSR_OP_RRF |=> o_status[0] == $past(i_ex_a[0]))
        else $error("rotate carry wrong");
    chk_power_values: assert property ($fell(i_srst) |-> o_status == 8'h18
        && o_option == 8'hFF && o_portb_dir == 8'hFF) else $error("power-on values wrong");
    chk_other_reset: assert property (i_other_rst && !i_por |=> o_status[7:5] == 3'h0
        && o_status[4] == !$past(i_wdt_reset) && o_status[3:0] == $past(o_status[3:0]))
        else $error("other reset values wrong");
    chk_unmapped_zero: assert property (psel && paddr[10:2] == 9'h185 |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    // Main scenarios reached
    cover property (st_fu && i_ex_op == `CSR_OP_CLEAR);
    cover property (st_fu && i_ex_op == `CSR_OP_SUB);
    cover property (i_other_rst && i_wdt_reset);
endmodule
bind csr_core_status_bank csr_status_monitor mon (.*);

// ---- verification/csr_core_status_bank_bench.sv ----
`timescale 1ns/1ps
`include "csr_defines.vh"
module csr_core_status_bank_bench;
    logic i_core_clk = 1'b0, i_srst = 1'b1, i_por = 1'b0, i_other_rst = 1'b0, i_wdt_reset = 1'b0;
    logic i_clrwdt = 1'b0, i_sleep = 1'b0, i_wdt_wake = 1'b0, i_ex_valid = 1'b0;
    logic i_ex_flag_update = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [2:0] i_ex_op = 3'h0;
    logic [8:0] i_ex_dest = 9'h000, o_mem_addr;
    logic [7:0] i_ex_a = 8'h00, i_ex_b = 8'h00, i_mem_rdata = 8'h5C, o_ex_result, o_mem_wdata;
    logic [7:0] o_status, o_option, o_portb_dir, o_int_ctrl, o_pc_low;
    logic [4:0] o_pc_latch;
    logic o_mem_we, pready, pslverr;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    int fail_count = 0, check_count = 0, cycles = 0;
    csr_core_status_bank uut (.*);
    // Core clock, 40 ns period
    initial begin
        forever #20 i_core_clk = ~i_core_clk;
    end
    task automatic print_verdict;
        if (fail_count == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Hang guard
    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles == 2000) begin
            fail_count++;
            $display("FAIL %0t timeout", $time);
            print_verdict();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer; read data left in rd
    task automatic apb(input logic wr, input logic [8:0] idx, input logic [31:0] wd);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {1'b0, idx, 2'h0};
        pwdata <= wd;
        @(posedge i_core_clk);
        penable <= 1'b1;
        do @(posedge i_core_clk); while (pready !== 1'b1);
        rd = prdata;
        chk({31'h0, pslverr}, 32'h0);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge i_core_clk);
    endtask
    // One instruction, then status compared
    task automatic ins(input logic [2:0] op, input logic [8:0] dst, input logic [7:0] a, b,
            input logic fu, input logic [7:0] exp);
        i_ex_valid <= 1'b1;
        i_ex_op <= op;
        i_ex_dest <= dst;
        i_ex_a <= a;
        i_ex_b <= b;
        i_ex_flag_update <= fu;
        @(posedge i_core_clk);
        i_ex_valid <= 1'b0;
        @(posedge i_core_clk);
        chk({24'h0, o_status}, {24'h0, exp});
    endtask
    // One-cycle pulse on {other reset, clrwdt, sleep, wake, wdt reset}, then status compared
    task automatic ev(input logic [4:0] v, input logic [7:0] exp);
        {i_other_rst, i_clrwdt, i_sleep, i_wdt_wake, i_wdt_reset} <= v;
        @(posedge i_core_clk);
        {i_other_rst, i_clrwdt, i_sleep, i_wdt_wake, i_wdt_reset} <= 5'h00;
        @(posedge i_core_clk);
        chk({24'h0, o_status}, {24'h0, exp});
    endtask
    task automatic t_reset_values;
        logic [8:0] idx [7] = '{9'h181, 9'h182, 9'h183, 9'h186, 9'h18A, 9'h18B, 9'h185};
        logic [7:0] exp [7] = '{8'hFF, 8'h00, 8'h18, 8'hFF, 8'h00, 8'h00, 8'h00};
        for (int k = 0; k < 7; k++) begin
            apb(1'b0, idx[k], 32'h0);
            chk(rd, {24'h0, exp[k]});
        end
    endtask
    task automatic t_bus_writes;
        apb(1'b1, `CSR_IDX_STATUS, 32'h0);
        apb(1'b0, `CSR_IDX_STATUS, 32'h0);
        chk(rd, 32'h18);
        apb(1'b1, 9'h185, 32'hFF);
        apb(1'b0, 9'h185, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, `CSR_IDX_PC_LATCH, 32'hFF);
        apb(1'b0, `CSR_IDX_PC_LATCH, 32'h0);
        chk(rd, 32'h1F);
        apb(1'b1, `CSR_IDX_POINTER, 32'h34);
        apb(1'b0, `CSR_IDX_INDIRECT_DATA, 32'h0);
        chk(rd, 32'h5C);
        chk({23'h0, o_mem_addr}, 32'h034);
    endtask
    task automatic t_indirect;
        i_ex_valid <= 1'b1;
        i_ex_op <= `CSR_OP_MOVE;
        i_ex_dest <= `CSR_IDX_INDIRECT_DATA;
        i_ex_b <= 8'h6A;
        i_ex_flag_update <= 1'b0;
        @(posedge i_core_clk);
        chk({23'h0, o_mem_we, o_mem_wdata}, 32'h16A);
        chk({24'h0, o_ex_result}, 32'h6A);
        chk({23'h0, o_mem_addr}, 32'h134);
        i_ex_valid <= 1'b0;
        @(posedge i_core_clk);
        chk({31'h0, o_mem_we}, 32'h0);
    endtask
    task automatic t_alu;
        ins(`CSR_OP_ADD, `CSR_IDX_STATUS, 8'h88, 8'h88, 1'b1, 8'h1B);
        ins(`CSR_OP_SUB, `CSR_IDX_STATUS, 8'h10, 8'h01, 1'b1, 8'h19);
        ins(`CSR_OP_SUB, `CSR_IDX_STATUS, 8'h01, 8'h02, 1'b1, 8'hF8);
        ins(`CSR_OP_CLEAR, `CSR_IDX_STATUS, 8'hFF, 8'hFF, 1'b1, 8'h1C);
        ins(`CSR_OP_RRF, `CSR_IDX_OPTION, 8'h01, 8'h00, 1'b1, 8'h1D);
        chk({24'h0, o_option}, 32'h0);
        ins(`CSR_OP_RLF, `CSR_IDX_OPTION, 8'h40, 8'h00, 1'b1, 8'h18);
        chk({24'h0, o_option}, 32'h81);
        ins(`CSR_OP_MOVE, `CSR_IDX_STATUS, 8'h00, 8'hA5, 1'b0, 8'hBD);
    endtask
    task automatic t_events;
        apb(1'b1, `CSR_IDX_INT_CTRL, 32'hFF);
        apb(1'b1, `CSR_IDX_PC_LOW, 32'h42);
        chk({24'h0, o_pc_low}, 32'h42);
        ev(5'h11, 8'h0D);
        chk({24'h0, o_int_ctrl}, 32'h01);
        chk({24'h0, o_pc_low}, 32'h00);
        chk({24'h0, o_mem_addr[7:0]}, 32'h34);
        ev(5'h04, 8'h15);
        ev(5'h02, 8'h05);
        ev(5'h08, 8'h1D);
        i_por <= 1'b1;
        @(posedge i_core_clk);
        i_por <= 1'b0;
        @(posedge i_core_clk);
        chk({16'h0, o_status, o_option}, 32'h18FF);
    endtask
    initial begin
        repeat (5) @(posedge i_core_clk);
        i_srst <= 1'b0;
        @(posedge i_core_clk);
        t_reset_values();
        t_bus_writes();
        t_alu();
        t_indirect();
        t_events();
        print_verdict();
    end
endmodule
